/* File: logic/ddi_ctrl_end.sv */
// What this block does
// - Fast refresh bit set for hot operation.
// - Second extended load only idle, then gap.
// - Third extended load only idle, then gap.
// - Third extended register written all zero.
// - Loaded mode values persist until reloaded.
// - Address bits above twelve, bank bit2 zero.
// - Only deselect for 200us, then raise clock-enable.
// - Clock-enable stays high through whole sequence.
// - Wait 400ns after clock-enable, precharge all.
// - Load second extended register, refresh-rate bit only.
// - Load third extended register, banks both high.
// - Load first extended register enabling DLL.
// - Load main register with DLL reset bit.
// - Normal use only 200 cycles after reset.
// - Precharge all, then two refreshes.
// - Load main register, operating values, no reset.
// - First extended load with calibration defaults set.
// - Reload first extended, calibration bits cleared.
// - Address bit10 means all banks; banks pick register.
// - Termination control held low during power-up.
// - Termination low eight clocks after enabling load.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module ddi_ctrl_end #(
  parameter int unsigned POWERUP_CYC_P = ddi_pkg::POWERUP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  ddi_link_if.ctrl         link,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  import ddi_pkg::*;

  ddi_state_t              state_q;
  ddi_state_t              state_d;
  logic [MODE_W-1:0]       mainVal_q;
  logic [MODE_W-1:0]       mainVal_d;
  logic [MODE_W-1:0]       ext1Val_q;
  logic [MODE_W-1:0]       ext1Val_d;
  logic                    fastRef_q;
  logic                    fastRef_d;
  logic [31:0]             prdata_q;
  logic [31:0]             prdata_d;
  logic                    pready_q;
  logic                    pready_d;
  logic                    pslverr_q;
  logic                    pslverr_d;
  logic                    cke_q;
  logic                    cke_d;
  logic                    csN_q;
  logic                    csN_d;
  logic [2:0]              cmd_q;
  logic [2:0]              cmd_d;
  logic [BA_W-1:0]         ba_q;
  logic [BA_W-1:0]         ba_d;
  logic [ADDR_W-1:0]       addr_q;
  logic [ADDR_W-1:0]       addr_d;
  logic                    setup;
  logic                    wrEn;
  logic                    mapped;
  logic                    startReq;
  logic                    busy;
  logic                    tmrLoad;
  logic [PWR_TMR_W-1:0]    tmrVal;
  logic                    tmrZero;
  logic                    lockLoad;
  logic                    lockZero;
  logic                    doLoad;
  logic [1:0]              lmBank;
  logic [MODE_W-1:0]       lmVal;

  ddi_timer #(.W(PWR_TMR_W)) gapTimer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .load    (tmrLoad),
    .loadVal (tmrVal),
    .zero    (tmrZero)
  );

  ddi_timer #(.W(LOCK_TMR_W)) lockTimer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .load    (lockLoad),
    .loadVal (LOCK_TMR_W'(DLL_LOCK_CYC - 1)),
    .zero    (lockZero)
  );

  // APB slave: one wait-free access phase, pready raised for it from the setup cycle.
  assign setup    = psel & ~penable;
  assign wrEn     = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign mapped   = (paddr == REG_CTRL) || (paddr == REG_MAIN) ||
                    (paddr == REG_EXT1) || (paddr == REG_STATUS);
  assign busy     = (state_q != ST_IDLE) && (state_q != ST_DONE);
  assign startReq = wrEn && (paddr == REG_CTRL) && pwdata[CTRL_START_BIT] && !busy;

  always_comb begin
    pready_d  = setup;
    pslverr_d = setup & ~mapped;
    prdata_d  = prdata_q;
    mainVal_d = mainVal_q;
    ext1Val_d = ext1Val_q;
    fastRef_d = fastRef_q;
    if (setup && !pwrite) begin
      prdata_d = '0;
      unique case (paddr)
        REG_CTRL: prdata_d[CTRL_FAST_REF_BIT] = fastRef_q;
        REG_MAIN: prdata_d[MODE_W-1:0] = mainVal_q;
        REG_EXT1: prdata_d[MODE_W-1:0] = ext1Val_q;
        REG_STATUS: begin
          prdata_d[STAT_BUSY_BIT]                  = busy;
          prdata_d[STAT_DONE_BIT]                  = (state_q == ST_DONE);
          prdata_d[STAT_FAST_REF_BIT]              = fastRef_q;
          prdata_d[STAT_STATE_LSB +: 4]            = state_q;
        end
        default: prdata_d = '0;
      endcase
    end
    if (wrEn) begin
      unique case (paddr)
        REG_CTRL: fastRef_d = pwdata[CTRL_FAST_REF_BIT];
        REG_MAIN: mainVal_d = pwdata[MODE_W-1:0];
        REG_EXT1: ext1Val_d = pwdata[MODE_W-1:0];
        default: ;
      endcase
    end
  end

  // Sequencer: each command state issues its command once the gap timer has run out.
  always_comb begin
    state_d  = state_q;
    cke_d    = cke_q;
    csN_d    = 1'b0;
    cmd_d    = CMD_NOP;
    ba_d     = '0;
    addr_d   = '0;
    tmrLoad  = 1'b0;
    tmrVal   = '0;
    lockLoad = 1'b0;
    doLoad   = 1'b0;
    lmBank   = BA_MAIN;
    lmVal    = '0;
    unique case (state_q)
      ST_IDLE, ST_DONE: begin
        csN_d = ~cke_q;
        if (startReq) begin
          state_d = ST_PWR;
          tmrLoad = 1'b1;
          tmrVal  = PWR_TMR_W'(POWERUP_CYC_P - 1);
        end
      end
      ST_PWR: begin
        csN_d = 1'b1;
        cke_d = 1'b0;
        if (tmrZero) begin
          cke_d   = 1'b1;
          state_d = ST_CKE;
          tmrLoad = 1'b1;
          tmrVal  = PWR_TMR_W'(CKE_WAIT_CYC - 1);
        end
      end
      ST_CKE, ST_PREA2: begin
        if (tmrZero) begin
          cmd_d                 = CMD_PRECHARGE;
          addr_d[ALL_BANKS_BIT] = 1'b1;
          state_d = (state_q == ST_CKE) ? ST_SECOND_EXTENDED_MODE_REG : ST_REF1;
          tmrLoad = 1'b1;
          tmrVal  = PWR_TMR_W'(PRECHARGE_GAP_CYC - 1);
        end
      end
      ST_SECOND_EXTENDED_MODE_REG: begin
        doLoad                           = tmrZero;
        lmBank                           = BA_EXT2;
        lmVal[REFRESH_RATE_OR_CALIB_BIT] = fastRef_q;
        if (tmrZero) state_d = ST_THIRD_EXTENDED_MODE_REG;
      end
      ST_THIRD_EXTENDED_MODE_REG: begin
        doLoad = tmrZero;
        lmBank = BA_EXT3;
        if (tmrZero) state_d = ST_DLLEN;
      end
      ST_DLLEN: begin
        doLoad = tmrZero;
        lmBank = BA_EXT1;
        if (tmrZero) state_d = ST_DLLRST;
      end
      ST_DLLRST: begin
        doLoad               = tmrZero;
        lmVal[DLL_RESET_BIT] = 1'b1;
        lockLoad             = tmrZero;
        if (tmrZero) state_d = ST_PREA2;
      end
      ST_REF1, ST_REF2: begin
        if (tmrZero) begin
          cmd_d   = CMD_REFRESH;
          state_d = (state_q == ST_REF1) ? ST_REF2 : ST_MROP;
          tmrLoad = 1'b1;
          tmrVal  = PWR_TMR_W'(REFRESH_GAP_CYC - 1);
        end
      end
      ST_MROP: begin
        doLoad               = tmrZero;
        lmVal                = mainVal_q;
        lmVal[DLL_RESET_BIT] = 1'b0;
        if (tmrZero) state_d = ST_OCDDEF;
      end
      ST_OCDDEF, ST_OCDEXIT: begin
        doLoad                 = tmrZero;
        lmBank                 = BA_EXT1;
        lmVal                  = ext1Val_q;
        lmVal[DLL_DISABLE_BIT] = 1'b0;
        lmVal[REFRESH_RATE_OR_CALIB_BIT +: CALIB_W] =
          (state_q == ST_OCDDEF) ? CALIB_DEFAULT : CALIB_EXIT;
        if (tmrZero) state_d = (state_q == ST_OCDDEF) ? ST_OCDEXIT : ST_LOCK;
      end
      ST_LOCK: begin
        if (tmrZero && lockZero) state_d = ST_DONE;
      end
      default: begin
        state_d = ST_IDLE;
        cke_d   = 1'b0;
      end
    endcase
    if (doLoad) begin
      cmd_d   = CMD_LOAD_MODE;
      ba_d    = {1'b0, lmBank};
      addr_d  = {{(ADDR_W - MODE_W){1'b0}}, lmVal};
      tmrLoad = 1'b1;
      tmrVal  = PWR_TMR_W'(MODE_LOAD_GAP_CYC - 1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q   <= ST_IDLE;
      mainVal_q <= MAIN_RST;
      ext1Val_q <= EXT1_RST;
      fastRef_q <= 1'b0;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      cke_q     <= 1'b0;
      csN_q     <= 1'b1;
      cmd_q     <= CMD_NOP;
      ba_q      <= '0;
      addr_q    <= '0;
    end else begin
      state_q   <= state_d;
      mainVal_q <= mainVal_d;
      ext1Val_q <= ext1Val_d;
      fastRef_q <= fastRef_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      cke_q     <= cke_d;
      csN_q     <= csN_d;
      cmd_q     <= cmd_d;
      ba_q      <= ba_d;
      addr_q    <= addr_d;
    end
  end

  // Termination control is never raised by this sequencer.
  assign link.termination_control  = 1'b0;
  assign link.cke  = cke_q;
  assign link.csN  = csN_q;
  assign link.rasN = cmd_q[2];
  assign link.casN = cmd_q[1];
  assign link.weN  = cmd_q[0];
  assign link.ba   = ba_q;
  assign link.addr = addr_q;
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
endmodule

/* File: logic/ddi_mem_end.sv */
`timescale 1ns/1ps
module ddi_mem_end (
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  ddi_link_if.mem                        link,
  output logic [ddi_pkg::MODE_W-1:0]     mainMode,
  output logic [ddi_pkg::MODE_W-1:0]     ext1Mode,
  output logic [ddi_pkg::MODE_W-1:0]     ext2Mode,
  output logic [ddi_pkg::MODE_W-1:0]     ext3Mode,
  output logic                           dllLocked,
  output logic                           initDone,
  output logic                           ready,
  output logic                           seqError
);
  import ddi_pkg::*;

  logic [MODE_W-1:0] mode_q [4];
  logic [MODE_W-1:0] mode_d [4];
  logic [3:0]        step_q;
  logic [3:0]        step_d;
  logic              done_q;
  logic              done_d;
  logic              err_q;
  logic              err_d;
  logic              armed_q;
  logic              armed_d;
  logic              locked_q;
  logic              locked_d;
  logic              ckeSeen_q;
  logic              ckeSeen_d;
  logic              ready_q;
  logic              gapLoad;
  logic              gapZero;
  logic              lockLoad;
  logic              lockZero;
  logic              live;
  logic              isLm;
  logic              isPre;
  logic              isRef;
  logic              stepOk;
  logic              stay;
  logic [1:0]        bank;
  logic [MODE_W-1:0] val;

  ddi_timer #(.W(PWR_TMR_W)) gapTimer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .load    (gapLoad),
    .loadVal (PWR_TMR_W'(MODE_LOAD_GAP_CYC - 1)),
    .zero    (gapZero)
  );

  ddi_timer #(.W(LOCK_TMR_W)) lockTimer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .load    (lockLoad),
    .loadVal (LOCK_TMR_W'(DLL_LOCK_CYC - 1)),
    .zero    (lockZero)
  );

  assign live  = link.cke & ~link.csN & ({link.rasN, link.casN, link.weN} != CMD_NOP);
  assign isLm  = {link.rasN, link.casN, link.weN} == CMD_LOAD_MODE;
  assign isRef = {link.rasN, link.casN, link.weN} == CMD_REFRESH;
  assign isPre = ({link.rasN, link.casN, link.weN} == CMD_PRECHARGE) &&
                 link.addr[ALL_BANKS_BIT];
  assign bank  = link.ba[1:0];
  assign val   = link.addr[MODE_W-1:0];

  // Expected step of the power-up order; step 8 accepts extra refreshes.
  always_comb begin
    stepOk = 1'b0;
    stay   = 1'b0;
    unique case (step_q)
      4'h0, 4'h5: stepOk = isPre;
      4'h1: stepOk = isLm && bank == BA_EXT2 &&
                     (val & ~(MODE_W'(1) << REFRESH_RATE_OR_CALIB_BIT)) == '0;
      4'h2: stepOk = isLm && bank == BA_EXT3 && val == '0;
      4'h3: stepOk = isLm && bank == BA_EXT1 &&
                     (val & ~(MODE_W'(7) << REFRESH_RATE_OR_CALIB_BIT)) == '0;
      4'h4: stepOk = isLm && bank == BA_MAIN && val == (MODE_W'(1) << DLL_RESET_BIT);
      4'h6, 4'h7: stepOk = isRef;
      4'h8: begin
        stay   = isRef;
        stepOk = isRef || (isLm && bank == BA_MAIN && !val[DLL_RESET_BIT]);
      end
      4'h9: stepOk = isLm && bank == BA_EXT1 && !val[DLL_DISABLE_BIT] &&
                     val[REFRESH_RATE_OR_CALIB_BIT +: CALIB_W] == CALIB_DEFAULT;
      4'hA: stepOk = isLm && bank == BA_EXT1 && !val[DLL_DISABLE_BIT] &&
                     val[REFRESH_RATE_OR_CALIB_BIT +: CALIB_W] == CALIB_EXIT;
      default: stepOk = 1'b0;
    endcase
  end

  always_comb begin
    mode_d    = mode_q;
    step_d    = step_q;
    done_d    = done_q;
    err_d     = err_q;
    armed_d   = armed_q;
    ckeSeen_d = ckeSeen_q | link.cke;
    gapLoad   = 1'b0;
    lockLoad  = 1'b0;
    if (live) begin
      if (!gapZero) err_d = 1'b1;
      if (isLm) begin
        mode_d[bank] = val;
        gapLoad      = 1'b1;
        if (link.addr[ADDR_W-1:MODE_W] != '0 || link.ba[BA_W-1]) err_d = 1'b1;
        if (bank == BA_MAIN && val[DLL_RESET_BIT]) begin
          lockLoad = 1'b1;
          armed_d  = 1'b1;
        end
      end
      if (!done_q) begin
        if (!stepOk) begin
          err_d = 1'b1;
        end else if (!stay) begin
          step_d = 4'(step_q + 4'h1);
          done_d = (step_q == 4'hA);
        end
      end
    end
    if (!done_q && (link.termination_control || (ckeSeen_q && !link.cke))) err_d = 1'b1;
    locked_d = armed_q && lockZero && !lockLoad;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q    <= '{default: '0};
      step_q    <= '0;
      done_q    <= 1'b0;
      err_q     <= 1'b0;
      armed_q   <= 1'b0;
      locked_q  <= 1'b0;
      ckeSeen_q <= 1'b0;
      ready_q   <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      step_q    <= step_d;
      done_q    <= done_d;
      err_q     <= err_d;
      armed_q   <= armed_d;
      locked_q  <= locked_d;
      ckeSeen_q <= ckeSeen_d;
      ready_q   <= done_d && locked_d;
    end
  end

  assign mainMode  = mode_q[BA_MAIN];
  assign ext1Mode  = mode_q[BA_EXT1];
  assign ext2Mode  = mode_q[BA_EXT2];
  assign ext3Mode  = mode_q[BA_EXT3];
  assign dllLocked = locked_q;
  assign initDone  = done_q;
  assign ready     = ready_q;
  assign seqError  = err_q;
endmodule

/* File: logic/ddi_timer.sv */
`timescale 1ns/1ps
module ddi_timer #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  output logic              zero
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // A load of N-1 makes zero seen at the N-th edge after the load edge.
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = loadVal;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign zero = (cnt_q == '0);
endmodule

/* File: shared/ddi_link_if.sv */
`timescale 1ns/1ps
interface ddi_link_if;
  logic                       cke;
  logic                       csN;
  logic                       rasN;
  logic                       casN;
  logic                       weN;
  logic [ddi_pkg::BA_W-1:0]   ba;
  logic [ddi_pkg::ADDR_W-1:0] addr;
  logic                       termination_control;

  modport ctrl (output cke, csN, rasN, casN, weN, ba, addr, termination_control);
  modport mem  (input cke, csN, rasN, casN, weN, ba, addr, termination_control);
endinterface

/* File: shared/ddi_pkg.sv */
package ddi_pkg;

  // Clock and timing figures.
  localparam int CLK_MHZ           = 25;
  localparam int CLK_PERIOD_NS     = 40;
  localparam int POWERUP_US        = 200;
  localparam int POWERUP_CYC       = POWERUP_US * CLK_MHZ;
  localparam int CKE_WAIT_NS       = 400;
  localparam int CKE_WAIT_CYC      = (CKE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_LOAD_GAP_CYC = 2;
  localparam int PRECHARGE_GAP_CYC = 2;
  localparam int REFRESH_GAP_CYC   = 4;
  localparam int DLL_LOCK_CYC      = 200;
  localparam int PWR_TMR_W         = 13;
  localparam int LOCK_TMR_W        = 8;

  // Link widths.
  localparam int ADDR_W = 16;
  localparam int BA_W   = 3;
  localparam int MODE_W = 13;

  // Mode register targets as decoded from the two low bank-select bits.
  localparam logic [1:0] BA_MAIN = 2'h0;
  localparam logic [1:0] BA_EXT1 = 2'h1;
  localparam logic [1:0] BA_EXT2 = 2'h2;
  localparam logic [1:0] BA_EXT3 = 2'h3;

  // Address bit positions inside a mode load or precharge.
  localparam int DLL_DISABLE_BIT           = 0;
  localparam int REFRESH_RATE_OR_CALIB_BIT = 7;
  localparam int DLL_RESET_BIT             = 8;
  localparam int ALL_BANKS_BIT             = 10;
  localparam int CALIB_W                   = 3;

  localparam logic [CALIB_W-1:0] CALIB_DEFAULT = 3'h7;
  localparam logic [CALIB_W-1:0] CALIB_EXIT    = 3'h0;

  // Command encodings on {rasN, casN, weN} with the chip selected.
  typedef enum logic [2:0] {
    CMD_LOAD_MODE = 3'h0,
    CMD_REFRESH   = 3'h1,
    CMD_PRECHARGE = 3'h2,
    CMD_NOP       = 3'h7
  } ddi_cmd_t;

  // Controller register map on APB.
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_MAIN   = 12'h004;
  localparam logic [11:0] REG_EXT1   = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;

  localparam int CTRL_START_BIT    = 0;
  localparam int CTRL_FAST_REF_BIT = 1;
  localparam int STAT_BUSY_BIT     = 0;
  localparam int STAT_DONE_BIT     = 1;
  localparam int STAT_FAST_REF_BIT = 2;
  localparam int STAT_STATE_LSB    = 4;

  localparam logic [MODE_W-1:0] MAIN_RST = 13'h0000;
  localparam logic [MODE_W-1:0] EXT1_RST = 13'h0000;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_PWR     = 4'h1,
    ST_CKE     = 4'h3,
    ST_SECOND_EXTENDED_MODE_REG    = 4'h2,
    ST_THIRD_EXTENDED_MODE_REG    = 4'h6,
    ST_DLLEN   = 4'h7,
    ST_DLLRST  = 4'h5,
    ST_PREA2   = 4'h4,
    ST_REF1    = 4'hC,
    ST_REF2    = 4'hD,
    ST_MROP    = 4'hF,
    ST_OCDDEF  = 4'hE,
    ST_OCDEXIT = 4'hA,
    ST_LOCK    = 4'hB,
    ST_DONE    = 4'h9
  } ddi_state_t;

endpackage

/* File: sim/ddi_link_props.sv */
`timescale 1ns/1ps
module ddi_link_props (
  input wire logic                       sys_clk,
  input wire logic                       srst,
  input wire logic                       cke,
  input wire logic                       csN,
  input wire logic                       rasN,
  input wire logic                       casN,
  input wire logic                       weN,
  input wire logic [ddi_pkg::BA_W-1:0]   ba,
  input wire logic [ddi_pkg::ADDR_W-1:0] addr,
  input wire logic                       termination_control
);
  import ddi_pkg::*;
  logic isCmd;
  logic isLoad;
  logic isPre;
  logic isRef;
  assign isCmd  = !csN && ({rasN, casN, weN} != CMD_NOP);
  assign isLoad = !csN && ({rasN, casN, weN} == CMD_LOAD_MODE);
  assign isPre  = !csN && ({rasN, casN, weN} == CMD_PRECHARGE);
  assign isRef  = !csN && ({rasN, casN, weN} == CMD_REFRESH);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_odt_off; termination_control == 1'b0; endproperty
  a_odt_off: assert property (p_odt_off)
    else $error("termination control raised");
  property p_quiet_cke_low; !cke |-> !isCmd; endproperty
  a_quiet_cke_low: assert property (p_quiet_cke_low)
    else $error("command while clock enable low");
  property p_cke_to_prea;
    $rose(cke) |-> (cke && !isCmd)[*8] ##1 (cke && !isCmd) ##1 (cke && !isCmd)
      ##[1:4] (isPre && addr[ALL_BANKS_BIT]);
  endproperty
  a_cke_to_prea: assert property (p_cke_to_prea)
    else $error("precharge-all timing after clock enable wrong");
  property p_load_reserved; isLoad |-> ba[2] == 1'b0 && addr[15:13] == 3'h0; endproperty
  a_load_reserved: assert property (p_load_reserved)
    else $error("reserved load bits not zero");
  property p_load_gap; isLoad |=> !isCmd; endproperty
  a_load_gap: assert property (p_load_gap)
    else $error("command inside mode load gap");
  property p_ref_gap; isRef |=> !isCmd[*3]; endproperty
  a_ref_gap: assert property (p_ref_gap)
    else $error("command inside refresh gap");
  property p_ext3_zero; isLoad && ba[1:0] == BA_EXT3 |-> addr == 16'h0000; endproperty
  a_ext3_zero: assert property (p_ext3_zero)
    else $error("third extended load not zero");
  property p_ext2_bits;
    isLoad && ba[1:0] == BA_EXT2 |-> (addr & 16'hFF7F) == 16'h0000;
  endproperty
  a_ext2_bits: assert property (p_ext2_bits)
    else $error("second extended load has stray bits");
  property p_early_order;
    isLoad && ba[1:0] == BA_EXT2 |-> ##2 (isLoad && ba[1:0] == BA_EXT3)
      ##2 (isLoad && ba[1:0] == BA_EXT1 && addr == 16'h0000)
      ##2 (isLoad && ba[1:0] == BA_MAIN && addr == 16'h0100);
  endproperty
  a_early_order: assert property (p_early_order)
    else $error("early load order wrong");
  property p_after_dll_reset;
    isLoad && ba[1:0] == BA_MAIN && addr[DLL_RESET_BIT] |-> ##2 (isPre && addr[ALL_BANKS_BIT])
      ##2 isRef ##4 isRef ##4 (isLoad && ba[1:0] == BA_MAIN && !addr[DLL_RESET_BIT]);
  endproperty
  a_after_dll_reset: assert property (p_after_dll_reset)
    else $error("steps after delay-loop reset wrong");
  property p_final_loads;
    isLoad && ba[1:0] == BA_MAIN && !addr[DLL_RESET_BIT] |->
      ##2 (isLoad && ba[1:0] == BA_EXT1 && addr[9:7] == CALIB_DEFAULT && !addr[0])
      ##2 (isLoad && ba[1:0] == BA_EXT1 && addr[9:7] == CALIB_EXIT && !addr[0]);
  endproperty
  a_final_loads: assert property (p_final_loads)
    else $error("calibration loads wrong");
endmodule

/* File: sim/sdram_powerup_init_sequence_test.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module sdram_powerup_init_sequence_test;
  import ddi_pkg::*;
  localparam int PWR = 20;
  logic              sys_clk = 1'b0;
  logic              srst    = 1'b1;
  logic [11:0]       paddr   = 12'h000;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [31:0]       pwdata  = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [MODE_W-1:0] mainMode;
  logic [MODE_W-1:0] ext1Mode;
  logic [MODE_W-1:0] ext2Mode;
  logic [MODE_W-1:0] ext3Mode;
  logic              dllLocked;
  logic              initDone;
  logic              ready;
  logic              seqError;
  logic              badSeqError;
  logic [31:0]       rd;
  logic              err;
  int                errors = 0;
  int                checks = 0;
  int                n;

  ddi_link_if link ();
  ddi_link_if link2 ();

  always #20 sys_clk = ~sys_clk;

  ddi_ctrl_end #(.POWERUP_CYC_P(PWR)) ddi_ctrl_end_i (.sys_clk(sys_clk), .srst(srst),
    .link(link), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ddi_mem_end ddi_mem_end_i (.sys_clk(sys_clk), .srst(srst), .link(link),
    .mainMode(mainMode), .ext1Mode(ext1Mode), .ext2Mode(ext2Mode), .ext3Mode(ext3Mode),
    .dllLocked(dllLocked), .initDone(initDone), .ready(ready), .seqError(seqError));
  // This end faces a bench driver that breaks the load format on purpose.
  ddi_mem_end ddi_mem_end_i2 (.sys_clk(sys_clk), .srst(srst), .link(link2),
    .mainMode(), .ext1Mode(), .ext2Mode(), .ext3Mode(), .dllLocked(), .initDone(),
    .ready(), .seqError(badSeqError));
  ddi_link_props ddi_link_props_i (.sys_clk(sys_clk), .srst(srst), .cke(link.cke),
    .csN(link.csN), .rasN(link.rasN), .casN(link.casN), .weN(link.weN), .ba(link.ba),
    .addr(link.addr), .termination_control(link.termination_control));

  task conclude;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task apb(input logic [11:0] a, input logic wr, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge sys_clk);
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= wd;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1);
    `CHK(k, 1)
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task waitCycles(input logic stopVal, input int limit);
    while (n < limit && link.cke !== stopVal) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  initial begin
    link2.cke = 1'b0;
    link2.csN = 1'b1;
    {link2.rasN, link2.casN, link2.weN} = 3'h7;
    link2.ba = 3'h0;
    link2.addr = 16'h0000;
    link2.termination_control = 1'b0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    apb(REG_STATUS, 1'b0, 32'h0);
    `CHK(rd[7:0], 8'h00)
    apb(12'h010, 1'b1, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
    apb(12'h010, 1'b0, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(REG_STATUS, 1'b1, 32'h0000_00FF);
    apb(REG_CTRL, 1'b0, 32'h0);
    `CHK({err, rd}, {1'b0, 32'h0})
    `CHK({mainMode, ext1Mode, ext2Mode, ext3Mode, initDone, ready}, 54'h0)
    apb(REG_EXT1, 1'b1, 32'h0000_0447);
    for (int r = 0; r < 2; r++) begin
      apb(REG_MAIN, 1'b1, r == 0 ? 32'h0000_1F32 : 32'h0000_0100);
      apb(REG_CTRL, 1'b1, r == 0 ? 32'h3 : 32'h1);
      n = 0;
      waitCycles(1'b0, 5);
      waitCycles(1'b1, 200);
      `CHK(n >= PWR && n <= PWR + 2, 1'b1)
      apb(REG_CTRL, 1'b1, r == 0 ? 32'h3 : 32'h1);
      n = 0;
      while (n < 100 && !(link.csN === 1'b0 && {link.rasN, link.casN, link.weN} === 3'h0
             && link.ba === 3'h0 && link.addr === 16'h0100)) begin
        @(posedge sys_clk);
        n++;
      end
      `CHK(n < 100, 1'b1)
      n = 0;
      while (r == 0 && n < 300 && dllLocked !== 1'b1) begin
        @(posedge sys_clk);
        n++;
      end
      if (r == 0) begin
        `CHK(n >= 199 && n <= 202, 1'b1)
      end
      repeat (230) @(posedge sys_clk);
      apb(REG_STATUS, 1'b0, 32'h0);
      `CHK(rd[7:0], {ST_DONE, 1'b0, r == 0, 2'b10})
      `CHK({ready, initDone, seqError}, 3'b110)
      `CHK(ext2Mode, r == 0 ? 13'h0080 : 13'h0000)
      `CHK(ext3Mode, 13'h0000)
      `CHK(mainMode, r == 0 ? 13'h1E32 : 13'h0000)
      `CHK(ext1Mode, 13'h0446)
      `CHK(link.cke, 1'b1)
      apb(REG_CTRL, 1'b0, 32'h0);
      `CHK(rd, r == 0 ? 32'h2 : 32'h0)
    end
    @(posedge sys_clk);
    link2.cke <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK(badSeqError, 1'b0)
    link2.csN <= 1'b0;
    {link2.rasN, link2.casN, link2.weN} <= 3'h2;
    link2.addr <= 16'h0400;
    @(posedge sys_clk);
    {link2.rasN, link2.casN, link2.weN} <= 3'h7;
    link2.addr <= 16'h0000;
    repeat (2) @(posedge sys_clk);
    `CHK(badSeqError, 1'b0)
    {link2.rasN, link2.casN, link2.weN} <= 3'h0;
    link2.ba <= 3'h6;
    @(posedge sys_clk);
    {link2.rasN, link2.casN, link2.weN} <= 3'h7;
    link2.ba <= 3'h0;
    repeat (3) @(posedge sys_clk);
    `CHK(badSeqError, 1'b1)
    conclude();
  end

  initial begin
    repeat (4000) @(posedge sys_clk);
    errors++;
    conclude();
  end
endmodule
